// ---- adc_command_result_control_tb_top.sv ----
// Self-checking bench for the converter control block
module adc_command_result_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_CMD = adcc_pkg::OFF_CMD;
  localparam logic [7:0] A_RES = adcc_pkg::OFF_RES;
  localparam logic [7:0] A_TST = adcc_pkg::OFF_TEST;
  localparam logic [7:0] A_STA = adcc_pkg::OFF_STAT;
  localparam logic [7:0] A_MSK = adcc_pkg::OFF_MASK;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic        prdy, perr, est, cab, smp, irq;
  logic [2:0]  chs;
  logic [9:0]  dac;
  logic [7:0]  chan_ctl = 8'h00;
  logic        evt = 1'b0;
  logic [9:0]  ain = 10'h000;
  logic [32:0] exp_q[$];
  logic [31:0] r = 32'hCB0ADF00;
  int          failures = 0;
  int          n_tests = 0;
  int          run = 0;
  int          last_run = 0;

  // Clock at 10 MHz
  always #50 clk = ~clk;

  adcc_ctrl adcc_ctrl_i (.CLK(clk), .SYS_RST(rst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
    .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .EVT_START(est),
    .CMP_ABOVE(cab), .CHAN_SEL(chs), .DAC_LEVEL(dac),
    .SAMPLE_EN(smp), .IRQ(irq));

  adcc_evt_model adcc_evt_model_i (.clk(clk), .rst(rst),
    .chan_ctl(chan_ctl), .evt(evt), .ain(ain), .dac(dac),
    .evt_start(est), .cmp_above(cab));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  task automatic cmp(input logic [32:0] got, input logic [32:0] e);
    n_tests++;
    if (got !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      i++;
    end while (prdy !== 1'b1 && i < 50);
    if (i >= 50) begin
      failures++;
      summarize();
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pulse();
    @(posedge clk);
    evt <= 1'b1;
    @(posedge clk);
    evt <= 1'b0;
  endtask

  task automatic wait_irq();
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 3000) begin
      @(negedge clk);
      i++;
    end
    if (i >= 3000) begin
      failures++;
      summarize();
    end
  endtask

  // Result, done flag and interrupt release after one conversion
  task automatic conv(input logic [2:0] c, input logic [9:0] v);
    wait_irq();
    cmp(33'(chs), 33'(c));
    rd(A_RES, {17'h0, v, 3'b000, c});
    rd(A_STA, 33'h20);
    @(negedge clk);
    cmp(33'(irq), 33'h0);
    @(posedge clk);
  endtask

  // Each completed read against the oldest noted value
  always @(posedge clk) begin
    if (psel && pen && !pwr && prdy) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("unexpected at %0t: got %h expected none", $time, prd);
      end else begin
        cmp({perr, prd}, exp_q.pop_front());
      end
    end
  end

  // Length of the last sampling window
  always @(posedge clk) begin
    if (smp === 1'b1) begin
      run++;
    end else if (run > 0) begin
      last_run = run;
      run = 0;
    end
  end

  // Main sequence
  initial begin
    logic [9:0] a;
    logic [7:0] rl;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(A_CMD, 33'h0);
    rd(adcc_pkg::OFF_TIME, 33'h33);
    rd(A_TST, 33'h1);
    rd(A_MSK, 33'h0);
    rd(A_RES, 33'h0);
    rd(8'h40, {1'b1, 32'h0});
    wr(adcc_pkg::OFF_TIME, 32'h32);
    wr(A_MSK, 32'h21);
    $display("end reset");
    for (int c = 0; c < 4; c++) begin
      wr(A_CMD, 32'h08 | 32'(c));
      wait_irq();
      rd(A_STA, 33'h1);
    end
    wr(A_MSK, 32'h20);
    wr(A_CMD, 32'h08);
    idle(5);
    cmp(33'(irq), 33'h0);
    rd(A_STA, 33'h1);
    $display("end channels");
    for (int k = 0; k < 4; k++) begin
      r = lfsr(r);
      a = {1'b0, r[8:0]} | 10'h004;
      ain <= a;
      wr(A_TST, k[1] ? 32'h3 : 32'h1);
      wr(A_CMD, {26'h0, 1'b0, k[0], 2'b11, r[10:9]});
      conv({1'b1, r[10:9]}, (a - 10'h001 - 10'(k[1]))
           & (k[0] ? 10'h3FF : 10'h3FC));
      cmp(33'(last_run), 33'h3);
    end
    wr(A_TST, 32'h0);
    wr(A_CMD, 32'h0C);
    idle(200);
    cmp(33'(irq), 33'h0);
    wr(A_STA, 32'h21);
    rd(A_STA, 33'h0);
    wr(A_TST, 32'h1);
    $display("end immediate");
    wr(A_CMD, 32'h15);
    pulse();
    idle(200);
    cmp(33'(irq), 33'h0);
    chan_ctl <= 8'h04;
    pulse();
    conv(3'h5, a - 10'h001);
    $display("end event");
    r = lfsr(r);
    rl = 8'h40 | {2'b00, r[5:0]};
    wr(A_RES, {16'h0, rl, 8'h00});
    ain <= {rl, 2'b00} - 10'h005;
    wr(A_CMD, 32'h2E);
    idle(300);
    cmp(33'(irq), 33'h0);
    rd(A_RES, {17'h0, a - 10'h001, 3'b001, 3'h6});
    for (int k = 0; k < 2; k++) begin
      ain <= k[0] ? {rl, 2'b00} - 10'h005 : {rl, 2'b00} + 10'h005;
      wr(A_CMD, k[0] ? 32'h3E : 32'h2E);
      conv(3'h6, {rl, 2'b00});
    end
    $display("end threshold");
    summarize();
  end
endmodule

// ---- adcc_ctrl.sv ----
// Converter command, result, timing and interrupt control over APB
// What this block does
// - Channel codes zero to three are refused as absent inputs
// - Command bit 3 clear waits for a start from the event array
// - Mode field picks 8-bit, 10-bit, threshold-high or threshold-low
// - Result shows channel, busy status and value; bits 5:4 read zero
// - Writing result high byte loads the threshold reference level
// - Sample and per-trial durations come from timing register; each trial adds CMP_LAT compare cycles
// - Test register enables conversions and holds offset compensation
// - Finished conversion sets pending bit 5 for an interrupt
module adcc_ctrl (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        EVT_START,
  input  wire logic        CMP_ABOVE,
  output logic [2:0]       CHAN_SEL,
  output logic [9:0]       DAC_LEVEL,
  output logic             SAMPLE_EN,
  output logic             IRQ
);
  logic [7:0]  cmd_q;
  logic [7:0]  time_q;
  logic [7:0]  test_q;
  logic [7:0]  stat_q;
  logic [7:0]  mask_q;
  logic [7:0]  ref_q;
  logic [2:0]  res_ch_q;
  logic        sw_go_q;
  logic        armed_q;
  logic        cmp_m_q;
  logic        cmp_s_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata;
  logic [7:0]  ev;
  logic        setup;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic        cmd_wr;
  logic        cmd_ok;
  logic        bad_ch;
  logic        en;
  logic        start_c;
  logic        abort;
  logic        busy;
  logic        done;
  logic [9:0]  value;
  adcc_pkg::adcc_mode_t mode;

  // Bus phase decode
  assign setup = PSEL && !PENABLE;
  assign wr    = PSEL && PENABLE && PWRITE;
  assign rd    = PSEL && PENABLE && !PWRITE;
  assign mapped = (PADDR == adcc_pkg::OFF_CMD) ||
                  (PADDR == adcc_pkg::OFF_RES) ||
                  (PADDR == adcc_pkg::OFF_TIME) ||
                  (PADDR == adcc_pkg::OFF_TEST) ||
                  (PADDR == adcc_pkg::OFF_STAT) ||
                  (PADDR == adcc_pkg::OFF_MASK);
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA  = prdata_q;

  // Command decode and start conditions
  assign cmd_wr = wr && (PADDR == adcc_pkg::OFF_CMD);
  assign bad_ch = cmd_wr && (PWDATA[2:0] < adcc_pkg::MIN_CH);
  assign cmd_ok = cmd_wr && !bad_ch;
  assign en     = test_q[adcc_pkg::TEST_EN];
  assign abort  = cmd_wr || !en;
  assign mode   = adcc_pkg::adcc_mode_t'(cmd_q[adcc_pkg::CMD_MODE +: 2]);
  assign start_c = en && !busy && !cmd_wr &&
                   (sw_go_q || (armed_q && EVT_START));

  // Comparator pin synchroniser
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cmp_m_q <= 1'b0;
      cmp_s_q <= 1'b0;
    end else begin
      cmp_m_q <= CMP_ABOVE;
      cmp_s_q <= cmp_m_q;
    end
  end

  // Command register
  always_ff @(posedge CLK) begin
    if (SYS_RST)     cmd_q <= adcc_pkg::CMD_RST;
    else if (cmd_wr) cmd_q <= PWDATA[7:0];
  end

  // Software start request and event arming
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sw_go_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (cmd_wr) begin
      sw_go_q <= cmd_ok && PWDATA[adcc_pkg::CMD_IMM];
      armed_q <= cmd_ok && !PWDATA[adcc_pkg::CMD_IMM];
    end else if (start_c) begin
      sw_go_q <= 1'b0;
    end
  end

  // Timing, test and mask registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      time_q <= adcc_pkg::TIME_RST;
      test_q <= adcc_pkg::TEST_RST;
      mask_q <= adcc_pkg::MASK_RST;
    end else if (wr) begin
      if (PADDR == adcc_pkg::OFF_TIME) time_q <= PWDATA[7:0];
      if (PADDR == adcc_pkg::OFF_TEST) test_q <= PWDATA[7:0];
      if (PADDR == adcc_pkg::OFF_MASK) mask_q <= PWDATA[7:0];
    end
  end

  // Threshold reference from the result high byte
  always_ff @(posedge CLK) begin
    if (SYS_RST) ref_q <= 8'h00;
    else if (wr && PADDR == adcc_pkg::OFF_RES) ref_q <= PWDATA[15:8];
  end

  // Channel of the conversion in progress
  always_ff @(posedge CLK) begin
    if (SYS_RST)      res_ch_q <= 3'h0;
    else if (start_c) res_ch_q <= cmd_q[2:0];
  end
  assign CHAN_SEL = res_ch_q;

  // Events into sticky status
  always_comb begin
    ev = 8'h00;
    ev[adcc_pkg::IRQ_DONE]  = done;
    ev[adcc_pkg::IRQ_BADCH] = bad_ch;
  end

  // Read clears only bits already returned; new events win
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      stat_q <= 8'h00;
    end else if (rd && PADDR == adcc_pkg::OFF_STAT) begin
      stat_q <= (stat_q & ~prdata_q[7:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  // Level interrupt from unmasked status
  assign IRQ = |(stat_q & mask_q);

  // Read data selection
  always_comb begin
    rdata = 32'h0000_0000;
    case (PADDR)
      adcc_pkg::OFF_CMD:  rdata[7:0] = cmd_q;
      adcc_pkg::OFF_RES:  rdata[15:0] = {value, 2'b00, busy, res_ch_q};
      adcc_pkg::OFF_TIME: rdata[7:0] = time_q;
      adcc_pkg::OFF_TEST: rdata[7:0] = test_q;
      adcc_pkg::OFF_STAT: rdata[7:0] = stat_q;
      adcc_pkg::OFF_MASK: rdata[7:0] = mask_q;
      default:            rdata = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge CLK) begin
    if (SYS_RST)    prdata_q <= 32'h0000_0000;
    else if (setup) prdata_q <= PWRITE ? 32'h0000_0000 : rdata;
  end

  // Conversion engine
  adcc_sar u_sar (
    .clk        (CLK),
    .rst        (SYS_RST),
    .start      (start_c),
    .abort      (abort),
    .mode       (mode),
    .sample_len (time_q[3:0]),
    .bit_len    (time_q[adcc_pkg::TIME_CONV +: 4]),
    .ofs        (test_q[adcc_pkg::TEST_OFS +: 4]),
    .ref_level  (ref_q),
    .cmp_above  (cmp_s_q),
    .busy       (busy),
    .done       (done),
    .sampling   (SAMPLE_EN),
    .value      (value),
    .dac_level  (DAC_LEVEL)
  );

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_bad_channel: assert property (
    bad_ch |=> stat_q[adcc_pkg::IRQ_BADCH] && !sw_go_q && !armed_q)
    else $error("absent channel code not refused");
  a_event_start: assert property (
    armed_q && EVT_START && en && !busy && !cmd_wr && !sw_go_q
      |=> busy && SAMPLE_EN)
    else $error("armed event did not start a conversion");
  a_idle_no_start: assert property (
    !busy && !sw_go_q && !armed_q && !cmd_wr |=> !busy)
    else $error("conversion began without any start source");
  a_eight_bit: assert property (
    done && mode == adcc_pkg::MODE_8B |=> value[1:0] == 2'b00)
    else $error("8-bit result has low bits set");
  a_res_reserved: assert property (
    rd && PADDR == adcc_pkg::OFF_RES |-> PRDATA[5:4] == 2'b00
      && PRDATA[31:16] == 16'h0000)
    else $error("result reserved bits not zero");
  a_ref_load: assert property (
    wr && PADDR == adcc_pkg::OFF_RES |=> ref_q == $past(PWDATA[15:8]))
    else $error("result high byte write did not load reference");
  a_disabled: assert property (
    !en |=> !busy ##1 (!busy || $past(en)))
    else $error("conversion runs while disabled");
  a_done_flag: assert property (
    done |=> stat_q[adcc_pkg::IRQ_DONE] ##1 stat_q[adcc_pkg::IRQ_DONE]
      || $past(rd && PADDR == adcc_pkg::OFF_STAT))
    else $error("completion did not set pending bit");

  // Register stores follow the written word
  a_cmd_store: assert property (
    cmd_wr |=> cmd_q == $past(PWDATA[7:0]))
    else $error("command write not stored");
  a_time_store: assert property (
    wr && PADDR == adcc_pkg::OFF_TIME
      |=> time_q == $past(PWDATA[7:0]))
    else $error("timing write not stored");
  a_test_store: assert property (
    wr && PADDR == adcc_pkg::OFF_TEST
      |=> test_q == $past(PWDATA[7:0]))
    else $error("test write not stored");
  a_mask_store: assert property (
    wr && PADDR == adcc_pkg::OFF_MASK
      |=> mask_q == $past(PWDATA[7:0]))
    else $error("mask write not stored");
  a_ref_hold: assert property (
    !(wr && PADDR == adcc_pkg::OFF_RES) |=> $stable(ref_q))
    else $error("reference changed without a result write");

  // Start sources and their lifetime
  a_sw_start: assert property (
    cmd_ok && PWDATA[adcc_pkg::CMD_IMM] |=> sw_go_q && !armed_q)
    else $error("immediate start not requested");
  a_sw_clear: assert property (
    start_c |=> !sw_go_q)
    else $error("software start request not consumed");
  a_armed_hold: assert property (
    armed_q && !cmd_wr |=> armed_q)
    else $error("event arming lost without a command write");
  a_unarmed_event: assert property (
    EVT_START && !armed_q && !sw_go_q && !busy |=> !busy)
    else $error("event started a conversion while not armed");
  a_cmd_abort: assert property (
    cmd_wr |=> !busy)
    else $error("command write did not stop the conversion");
  a_busy_hold: assert property (
    busy && !done && en && !cmd_wr |=> busy)
    else $error("conversion ended before completion");

  // Channel of the running conversion
  a_chan_load: assert property (
    start_c |=> CHAN_SEL == $past(cmd_q[2:0]))
    else $error("channel not taken at start");
  a_chan_valid: assert property (
    busy |-> CHAN_SEL >= adcc_pkg::MIN_CH)
    else $error("conversion runs on an absent channel");
  a_res_status: assert property (
    rd && PADDR == adcc_pkg::OFF_RES
      |-> PRDATA[15:0] == $past({value, 2'b00, busy, CHAN_SEL}))
    else $error("result read does not match converter state");

  // Pending flags and the interrupt level
  a_stat_clear: assert property (
    rd && PADDR == adcc_pkg::OFF_STAT && !done
      |=> (stat_q & $past(PRDATA[7:0])) == 8'h00)
    else $error("status read did not clear returned bits");
  a_stat_ro: assert property (
    wr && PADDR == adcc_pkg::OFF_STAT && !done |=> $stable(stat_q))
    else $error("status changed by a write");
  a_irq_done: assert property (
    stat_q[adcc_pkg::IRQ_DONE] && mask_q[adcc_pkg::IRQ_DONE] |-> IRQ)
    else $error("unmasked completion without interrupt");
  a_irq_badch: assert property (
    stat_q[adcc_pkg::IRQ_BADCH] && mask_q[adcc_pkg::IRQ_BADCH] |-> IRQ)
    else $error("unmasked channel refusal without interrupt");
  a_irq_quiet: assert property (
    (stat_q & mask_q) == 8'h00 |-> !IRQ)
    else $error("interrupt without an unmasked flag");

  c_sw_done: cover property (sw_go_q && start_c ##[1:300] done);
  c_evt_done: cover property (armed_q && EVT_START && start_c);
  c_badch: cover property (bad_ch);
  c_irq: cover property (done ##1 IRQ);
endmodule

// ---- adcc_evt_model.sv ----
// Event array start source and analog comparator model
module adcc_evt_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] chan_ctl,
  input  wire logic       evt,
  input  wire logic [9:0] ain,
  input  wire logic [9:0] dac,
  output logic            evt_start,
  output logic            cmp_above
);
  timeunit 1ns;
  timeprecision 1ns;
  // Start request only when the channel allows it
  always_ff @(posedge clk) begin
    if (rst) begin
      evt_start <= 1'b0;
    end else begin
      evt_start <= evt & chan_ctl[2];
    end
  end
  // Input compared against the trial level
  assign cmp_above = (ain > dac);
endmodule

// ---- adcc_pkg.sv ----
// Register map, field positions, reset values and state types
package adcc_pkg;
  // Byte offsets of the word registers
  localparam logic [7:0] OFF_CMD  = 8'h00;
  localparam logic [7:0] OFF_RES  = 8'h04;
  localparam logic [7:0] OFF_TIME = 8'h08;
  localparam logic [7:0] OFF_TEST = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  // Field positions
  localparam int CMD_IMM   = 3;
  localparam int CMD_MODE  = 4;
  localparam int RES_BUSY  = 3;
  localparam int RES_VAL   = 6;
  localparam int IRQ_BADCH = 0;
  localparam int IRQ_DONE  = 5;
  localparam int TEST_EN   = 0;
  localparam int TEST_OFS  = 1;
  localparam int TIME_CONV = 4;
  // Lowest channel code that selects a present input
  localparam logic [2:0] MIN_CH = 3'h4;
  // Reset values
  localparam logic [7:0] CMD_RST  = 8'h00;
  localparam logic [7:0] TIME_RST = 8'h33;
  localparam logic [7:0] TEST_RST = 8'h01;
  localparam logic [7:0] MASK_RST = 8'h00;
  // Cycles from a new trial level to a settled, synchronised compare
  localparam logic [4:0] CMP_LAT  = 5'h03;
  localparam logic [9:0] SAR_MSB  = 10'h200;
  typedef enum logic [1:0] {
    MODE_8B     = 2'h0,
    MODE_10B    = 2'h1,
    MODE_THR_HI = 2'h2,
    MODE_THR_LO = 2'h3
  } adcc_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b11,
    ST_DONE   = 2'b10
  } adcc_state_t;
endpackage

// ---- adcc_sar.sv ----
// Successive approximation sequencer with threshold compare
module adcc_sar (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 start,
  input  wire logic                 abort,
  input  wire adcc_pkg::adcc_mode_t mode,
  input  wire logic [3:0]           sample_len,
  input  wire logic [3:0]           bit_len,
  input  wire logic [3:0]           ofs,
  input  wire logic [7:0]           ref_level,
  input  wire logic                 cmp_above,
  output logic                      busy,
  output logic                      done,
  output logic                      sampling,
  output logic [9:0]                value,
  output logic [9:0]                dac_level
);
  adcc_pkg::adcc_state_t state_q;
  logic [4:0] cnt_q;
  logic [3:0] bit_q;
  logic [9:0] sar_q;
  logic [4:0] seen_q;
  logic       thr;
  logic       last;
  logic       hit;

  // Mode decode
  assign thr  = mode[1];
  assign last = (mode == adcc_pkg::MODE_8B) ? (bit_q == 4'h2)
                                            : (bit_q == 4'h0);
  assign hit  = (mode == adcc_pkg::MODE_THR_HI) ? cmp_above : !cmp_above;
  assign busy     = (state_q != adcc_pkg::ST_IDLE);
  assign done     = (state_q == adcc_pkg::ST_DONE);
  assign sampling = (state_q == adcc_pkg::ST_SAMPLE);

  // Sample, trial and decide sequence
  always_ff @(posedge clk) begin
    if (rst || abort) begin
      state_q <= adcc_pkg::ST_IDLE;
      cnt_q   <= 5'h00;
      bit_q   <= 4'h9;
      sar_q   <= 10'h000;
    end else begin
      unique case (state_q)
        adcc_pkg::ST_IDLE: if (start) begin
          state_q <= adcc_pkg::ST_SAMPLE;
          cnt_q   <= {1'b0, sample_len};
          bit_q   <= 4'h9;
          sar_q   <= thr ? {ref_level, 2'b00} : adcc_pkg::SAR_MSB;
        end
        adcc_pkg::ST_SAMPLE: if (cnt_q == 5'h00) begin
          state_q <= adcc_pkg::ST_CONV;
          cnt_q   <= {1'b0, bit_len} + adcc_pkg::CMP_LAT;
        end else begin
          cnt_q <= cnt_q - 5'h01;
        end
        adcc_pkg::ST_CONV: if (cnt_q != 5'h00) begin
          cnt_q <= cnt_q - 5'h01;
        end else if (thr) begin
          // Only a crossing completes, otherwise resample
          if (hit) begin
            state_q <= adcc_pkg::ST_DONE;
          end else begin
            state_q <= adcc_pkg::ST_SAMPLE;
            cnt_q   <= {1'b0, sample_len};
          end
        end else begin
          sar_q[bit_q] <= cmp_above;
          if (last) begin
            state_q <= adcc_pkg::ST_DONE;
          end else begin
            sar_q[bit_q - 4'h1] <= 1'b1;
            bit_q <= bit_q - 4'h1;
            cnt_q <= {1'b0, bit_len} + adcc_pkg::CMP_LAT;
          end
        end
        adcc_pkg::ST_DONE: state_q <= adcc_pkg::ST_IDLE;
      endcase
    end
  end

  // Result and trial level with offset compensation
  always_ff @(posedge clk) begin
    if (rst) begin
      value     <= 10'h000;
      dac_level <= 10'h000;
    end else begin
      if (done) value <= sar_q;
      dac_level <= sar_q + {{6{ofs[3]}}, ofs};
    end
  end

  // Length of the sampling window seen so far
  always_ff @(posedge clk) begin
    if (rst || !sampling) seen_q <= 5'h00;
    else                  seen_q <= seen_q + 5'h01;
  end

  a_sample_time: assert property (@(posedge clk) disable iff (rst)
    $fell(sampling) && !abort && !$past(abort)
      |-> seen_q == 5'({1'b0, $past(sample_len)} + 5'h01))
    else $error("sampling window length differs from timing field");
  a_thr_hit: assert property (@(posedge clk) disable iff (rst)
    done && mode == adcc_pkg::MODE_THR_HI |-> $past(cmp_above))
    else $error("high threshold completed without crossing");
  a_thr_retry: assert property (@(posedge clk) disable iff (rst)
    state_q == adcc_pkg::ST_CONV && thr && cnt_q == 5'h00 && !hit
      && !abort |=> sampling)
    else $error("threshold miss did not resample");
  c_thr_done: cover property (@(posedge clk) disable iff (rst)
    done && thr);
endmodule
